// ---- design/src_sleep_reset_ctrl.sv ----
// Sleep mode, clock gate and reset source controller with an APB register port.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module src_sleep_reset_ctrl #(
	parameter int STARTUP_CYCLES = src_pkg::STARTUP_CYCLES
) (
	// Clock and bus reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Reset sources.
	input wire logic supply_ok,
	input wire logic reset_pin_n,
	input wire logic reset_pin_en,
	input wire logic watchdog_timeout,
	input wire logic supply_below_level,
	input wire logic supply_below_reset,
	// Core and peripherals.
	input wire logic sleep_instr,
	input wire logic wake_irq,
	input wire logic watchdog_enable,
	input wire logic converter_enable,
	output logic core_reset_n,
	output logic port_reset_n,
	output logic core_halt,
	output logic clk_cpu_en,
	output logic clk_io_en,
	output logic clk_converter_en,
	output logic clk_timer_en,
	output logic oscillator_en,
	output logic comparator_en,
	output logic mux_share_en,
	output logic input_buffer_en,
	output logic watchdog_run,
	output logic extended_conversion,
	output logic supply_low_irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Synchronised inputs.

	logic supply_ok_s;
	logic reset_pin_s;
	logic below_level_s;
	logic below_reset_s;

	src_sync #(.RESET_VALUE(1'b0)) u_sync_supply (
		.pclk(pclk), .presetn(presetn), .async_in(supply_ok), .sync_out(supply_ok_s));
	src_sync #(.RESET_VALUE(1'b1)) u_sync_pin (
		.pclk(pclk), .presetn(presetn), .async_in(reset_pin_n), .sync_out(reset_pin_s));
	src_sync #(.RESET_VALUE(1'b0)) u_sync_level (
		.pclk(pclk), .presetn(presetn), .async_in(supply_below_level), .sync_out(below_level_s));
	src_sync #(.RESET_VALUE(1'b0)) u_sync_rlevel (
		.pclk(pclk), .presetn(presetn), .async_in(supply_below_reset), .sync_out(below_reset_s));

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	logic [3:0] sleep_control_reg;
	logic [1:0] clock_gate_reg;
	logic [2:0] supply_trigger_level;
	logic supply_monitor_reset_mode;
	logic supply_low_irq_en;
	logic supply_low_flag;
	logic power_up_reset_flag;
	logic pin_reset_flag;
	logic watchdog_reset_flag;
	logic converter_was_on;
	src_pkg::src_power_t power_state;
	logic [2:0] halt_count;
	logic wake_pending;

	wire sleep_arm = sleep_control_reg[src_pkg::SLEEP_ARM_BIT];
	wire [2:0] sleep_kind_select = sleep_control_reg[src_pkg::SLEEP_KIND_LSB +: 3];
	wire converter_clock_gate = clock_gate_reg[src_pkg::CONVERTER_GATE_BIT];
	wire timer_clock_gate = clock_gate_reg[src_pkg::TIMER_GATE_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Reset sources and delay counter.

	// Power-on and pin reset act asynchronously so ports react without a clock.
	// The clocked sources (watchdog, supply monitor) reach the ports through the core reset.
	wire pin_active = reset_pin_en && !reset_pin_n;
	assign port_reset_n = presetn && supply_ok && !pin_active && core_reset_n;

	localparam int CW = $clog2(STARTUP_CYCLES + 1);
	localparam logic [CW-1:0] DELAY_LOAD = CW'(STARTUP_CYCLES);
	logic [CW-1:0] delay_count;
	logic por_phase;
	logic wdt_pulse;
	logic wdt_prev;

	wire pin_low_s = reset_pin_en && !reset_pin_s;
	wire vlm_reset = supply_monitor_reset_mode && below_reset_s;
	// During the power-on count the pin is ignored; only its level at the end matters.
	wire pin_hold = pin_low_s && !(por_phase && delay_count != '0);
	wire any_source = !supply_ok_s || pin_hold || vlm_reset || wdt_pulse;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_pulse <= 1'b0;
			wdt_prev <= 1'b0;
		end else begin
			// Only the rising edge counts, so a held time-out level gives one pulse.
			wdt_prev <= watchdog_timeout;
			wdt_pulse <= watchdog_timeout && !wdt_prev;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			delay_count <= DELAY_LOAD;
			por_phase <= 1'b1;
			core_reset_n <= 1'b0;
		end else if (any_source) begin
			delay_count <= DELAY_LOAD;
			por_phase <= !supply_ok_s || vlm_reset || por_phase;
			core_reset_n <= 1'b0;
		end else if (delay_count != '0) begin
			delay_count <= delay_count - CW'(1);
			core_reset_n <= 1'b0;
		end else begin
			por_phase <= 1'b0;
			core_reset_n <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB register access.

	wire wr_en = psel && penable && pwrite;
	wire sel_sleep = paddr == src_pkg::SLEEP_CONTROL_ADDR;
	wire sel_gate = paddr == src_pkg::CLOCK_GATE_ADDR;
	wire sel_mon = paddr == src_pkg::SUPPLY_MONITOR_ADDR;
	wire sel_flags = paddr == src_pkg::RESET_FLAG_ADDR;
	wire sel_stat = paddr == src_pkg::STATUS_ADDR;
	wire mapped = sel_sleep || sel_gate || sel_mon || sel_flags || sel_stat;
	wire [2:0] wr_level = pwdata[src_pkg::TRIGGER_LSB +: 3];
	wire level_change = wr_en && sel_mon && wr_level != supply_trigger_level;
	wire flag_zero_write = wr_en && sel_mon && !pwdata[src_pkg::LOW_FLAG_BIT];
	wire [31:0] rd_mux =
		sel_sleep ? {28'h000_0000, sleep_control_reg} :
		sel_gate ? {30'h0000_0000, clock_gate_reg} :
		sel_mon ? {26'h000_0000, supply_low_flag, supply_low_irq_en,
			supply_monitor_reset_mode, supply_trigger_level} :
		sel_flags ? {29'h0000_0000, watchdog_reset_flag, pin_reset_flag, power_up_reset_flag} :
		sel_stat ? {29'h0000_0000, power_state} : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// The control registers are cleared by the stretched internal reset as well as the bus reset; the reset cause flags are not.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_control_reg <= src_pkg::SLEEP_CONTROL_RESET;
			clock_gate_reg <= src_pkg::CLOCK_GATE_RESET;
			supply_trigger_level <= src_pkg::TRIGGER_RESET;
			supply_monitor_reset_mode <= 1'b0;
			supply_low_irq_en <= 1'b0;
		end else if (!core_reset_n) begin
			sleep_control_reg <= src_pkg::SLEEP_CONTROL_RESET;
			clock_gate_reg <= src_pkg::CLOCK_GATE_RESET;
			supply_trigger_level <= src_pkg::TRIGGER_RESET;
			supply_monitor_reset_mode <= 1'b0;
			supply_low_irq_en <= 1'b0;
		end else if (wr_en && pready) begin
			if (sel_sleep) begin
				sleep_control_reg <= pwdata[3:0];
			end
			if (sel_gate) begin
				clock_gate_reg <= pwdata[1:0];
			end
			if (sel_mon) begin
				supply_trigger_level <= wr_level;
				supply_monitor_reset_mode <= pwdata[src_pkg::RESET_MODE_BIT];
				supply_low_irq_en <= pwdata[src_pkg::IRQ_EN_BIT];
			end
		end
	end

	// The supply flag follows the comparator; a clear wins over a low reading in its cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			supply_low_flag <= 1'b0;
			supply_low_irq <= 1'b0;
		end else begin
			if (!core_reset_n || !below_level_s) begin
				supply_low_flag <= 1'b0;
			end else if (pready && (level_change || flag_zero_write)) begin
				supply_low_flag <= 1'b0;
			end else begin
				supply_low_flag <= 1'b1;
			end
			supply_low_irq <= supply_low_flag && supply_low_irq_en;
		end
	end

	// Reset cause flags: set wins over a zero write from software.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_up_reset_flag <= 1'b1;
			pin_reset_flag <= 1'b0;
			watchdog_reset_flag <= 1'b0;
		end else if (!supply_ok_s) begin
			power_up_reset_flag <= 1'b1;
		end else begin
			if (wr_en && pready && sel_flags) begin
				power_up_reset_flag <= pwdata[0];
				pin_reset_flag <= pwdata[1] || pin_hold;
				watchdog_reset_flag <= pwdata[2] || wdt_pulse;
			end else begin
				pin_reset_flag <= pin_reset_flag || pin_hold;
				watchdog_reset_flag <= watchdog_reset_flag || wdt_pulse;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sleep state machine.

	wire sleep_go = sleep_instr && sleep_arm;
	src_pkg::src_power_t next_power_state;

	always_comb begin
		next_power_state = power_state;
		unique case (power_state)
			src_pkg::SRC_RUN: begin
				if (sleep_go) begin
					next_power_state = src_pkg::SRC_SLEEP;
				end
			end
			src_pkg::SRC_SLEEP: begin
				if (wake_irq) begin
					next_power_state = src_pkg::SRC_WAKE;
				end
			end
			src_pkg::SRC_WAKE: begin
				if (halt_count == '0) begin
					next_power_state = src_pkg::SRC_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_state <= src_pkg::SRC_RUN;
			halt_count <= 3'h0;
			wake_pending <= 1'b0;
		end else if (!core_reset_n) begin
			power_state <= src_pkg::SRC_RUN;
			halt_count <= 3'h0;
			wake_pending <= 1'b0;
		end else begin
			power_state <= next_power_state;
			wake_pending <= power_state == src_pkg::SRC_SLEEP && wake_irq;
			if (power_state == src_pkg::SRC_SLEEP && wake_irq) begin
				halt_count <= 3'(src_pkg::WAKE_HALT_CYCLES - 1);
			end else if (halt_count != '0) begin
				halt_count <= halt_count - 3'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Clock domain and peripheral controls.

	wire asleep = power_state == src_pkg::SRC_SLEEP;
	wire k_idle = asleep && sleep_kind_select == src_pkg::KIND_IDLE;
	wire k_noise = asleep && sleep_kind_select == src_pkg::KIND_NOISE;
	wire k_pd = asleep && sleep_kind_select == src_pkg::KIND_POWER_DOWN;
	wire k_sb = asleep && sleep_kind_select == src_pkg::KIND_STANDBY;
	// Reserved codes sleep like idle: the safest choice, since the core is merely halted.
	wire io_stop = k_noise || k_pd || k_sb;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_halt <= 1'b1;
			clk_cpu_en <= 1'b0;
			clk_io_en <= 1'b0;
			clk_converter_en <= 1'b0;
			clk_timer_en <= 1'b0;
			oscillator_en <= 1'b1;
			comparator_en <= 1'b0;
			mux_share_en <= 1'b0;
			input_buffer_en <= 1'b0;
			watchdog_run <= 1'b0;
			extended_conversion <= 1'b0;
			converter_was_on <= 1'b0;
		end else begin
			core_halt <= !core_reset_n || power_state != src_pkg::SRC_RUN;
			clk_cpu_en <= core_reset_n && !asleep && power_state != src_pkg::SRC_WAKE;
			clk_io_en <= !io_stop;
			clk_converter_en <= !converter_clock_gate && !(k_pd || k_sb);
			clk_timer_en <= !timer_clock_gate && !io_stop;
			oscillator_en <= !k_pd;
			comparator_en <= !k_pd;
			mux_share_en <= !converter_clock_gate;
			input_buffer_en <= !io_stop;
			watchdog_run <= watchdog_enable;
			converter_was_on <= converter_enable;
			if (converter_enable && !converter_was_on) begin
				extended_conversion <= 1'b1;
			end else if (!converter_enable) begin
				extended_conversion <= extended_conversion;
			end
		end
	end

	wire unused_ok = k_idle || wake_pending;

endmodule : src_sleep_reset_ctrl

// ---- design/src_pkg.sv ----
// Package for the sleep and reset controller: offsets, fields, codes and counts.
package src_pkg;

	// Register byte addresses.
	localparam logic [7:0] SLEEP_CONTROL_ADDR = 8'h00;
	localparam logic [7:0] CLOCK_GATE_ADDR = 8'h04;
	localparam logic [7:0] SUPPLY_MONITOR_ADDR = 8'h08;
	localparam logic [7:0] RESET_FLAG_ADDR = 8'h0C;
	localparam logic [7:0] STATUS_ADDR = 8'h10;

	// Field positions.
	localparam int SLEEP_ARM_BIT = 0;
	localparam int SLEEP_KIND_LSB = 1;
	localparam int TIMER_GATE_BIT = 0;
	localparam int CONVERTER_GATE_BIT = 1;
	localparam int TRIGGER_LSB = 0;
	localparam int RESET_MODE_BIT = 3;
	localparam int IRQ_EN_BIT = 4;
	localparam int LOW_FLAG_BIT = 5;

	// Reset values.
	localparam logic [3:0] SLEEP_CONTROL_RESET = 4'h0;
	localparam logic [1:0] CLOCK_GATE_RESET = 2'h0;
	localparam logic [2:0] TRIGGER_RESET = 3'h0;

	// Sleep kinds.
	localparam logic [2:0] KIND_IDLE = 3'h0;
	localparam logic [2:0] KIND_NOISE = 3'h1;
	localparam logic [2:0] KIND_POWER_DOWN = 3'h2;
	localparam logic [2:0] KIND_STANDBY = 3'h4;

	// Start-up stretch and wake halt, in system clock cycles.
	localparam int STARTUP_CYCLES = 64;
	localparam int WAKE_HALT_CYCLES = 4;
	localparam int SYNC_STAGES = 3;

	typedef enum logic [2:0] {
		SRC_RUN = 3'b001,
		SRC_SLEEP = 3'b010,
		SRC_WAKE = 3'b100
	} src_power_t;

endpackage : src_pkg

// ---- design/src_sync.sv ----
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module src_sync #(
	parameter logic RESET_VALUE = 1'b0
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Asynchronous input and filtered output.
	input wire logic async_in,
	output logic sync_out
);
	logic [2:0] stage;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage <= {3{RESET_VALUE}};
			sync_out <= RESET_VALUE;
		end else begin
			stage <= {stage[1:0], async_in};
			if (stage[1] == stage[2]) begin
				sync_out <= stage[2];
			end
		end
	end
endmodule : src_sync

// ---- tb/src_props.sv ----
// Concurrent checks on the ports of the sleep and reset controller.
`timescale 1ns/1ps
module src_props #(
	parameter int STARTUP_CYCLES = 64
) (
	// Clock, reset and bus.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// Reset sources.
	input wire logic supply_ok,
	input wire logic reset_pin_n,
	input wire logic reset_pin_en,
	input wire logic watchdog_timeout,
	input wire logic watchdog_enable,
	input wire logic supply_below_level,
	// Controlled outputs.
	input wire logic core_reset_n,
	input wire logic port_reset_n,
	input wire logic clk_cpu_en,
	input wire logic clk_io_en,
	input wire logic oscillator_en,
	input wire logic comparator_en,
	input wire logic watchdog_run,
	input wire logic supply_low_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// Cycles of unbroken good supply, so the stretch can be measured.
	logic [15:0] ok_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ok_cnt <= 16'h0000;
		end else if (!supply_ok) begin
			ok_cnt <= 16'h0000;
		end else if (ok_cnt != 16'hFFFF) begin
			ok_cnt <= ok_cnt + 16'h0001;
		end
	end
	////////////////////////////////////////////////////////////////
	AST_PORT_RESET: assert property (!supply_ok || (reset_pin_en && !reset_pin_n) |-> !port_reset_n)
		else $error("port reset not active with a source active");
	AST_SUPPLY_HOLD: assert property ((!supply_ok) [*6] |-> !core_reset_n)
		else $error("core reset released under low supply");
	AST_PIN_HOLD: assert property ((reset_pin_en && !reset_pin_n) [*6] |-> !core_reset_n)
		else $error("core reset released with pin held low");
	AST_WDOG_RESET: assert property ($rose(watchdog_timeout) && watchdog_enable && core_reset_n
		|-> ##[1:5] !core_reset_n)
		else $error("watchdog time-out gave no reset");
	AST_STRETCH: assert property ($rose(core_reset_n) |-> ok_cnt >= STARTUP_CYCLES)
		else $error("internal reset released before the delay count");
	AST_PD_COMPARATOR: assert property (!oscillator_en && core_reset_n |-> !comparator_en)
		else $error("comparator on while oscillator stopped");
	AST_CLOCK_ORDER: assert property (clk_cpu_en |-> clk_io_en)
		else $error("core clock runs while io clock stopped");
	AST_RD_SLEEP_ZERO: assert property (pready && !pwrite && paddr == src_pkg::SLEEP_CONTROL_ADDR
		|-> prdata[31:4] == 28'h000_0000)
		else $error("sleep control upper bits not zero");
	AST_RD_GATE_ZERO: assert property (pready && !pwrite && paddr == src_pkg::CLOCK_GATE_ADDR
		|-> prdata[31:2] == 30'h0000_0000)
		else $error("clock gate upper bits not zero");
	AST_WDOG_RUN: assert property ((watchdog_enable && core_reset_n) [*3] |-> watchdog_run)
		else $error("enabled watchdog not running");
	AST_IRQ_CLEAR: assert property ((!supply_below_level) [*7] |-> !supply_low_irq)
		else $error("supply low request stays after recovery");
endmodule : src_props
bind src_sleep_reset_ctrl src_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) src_props_inst (
	.pclk(pclk), .presetn(presetn), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .supply_ok(supply_ok), .reset_pin_n(reset_pin_n),
	.reset_pin_en(reset_pin_en), .watchdog_timeout(watchdog_timeout),
	.watchdog_enable(watchdog_enable), .supply_below_level(supply_below_level),
	.core_reset_n(core_reset_n), .port_reset_n(port_reset_n), .clk_cpu_en(clk_cpu_en),
	.clk_io_en(clk_io_en), .oscillator_en(oscillator_en), .comparator_en(comparator_en),
	.watchdog_run(watchdog_run), .supply_low_irq(supply_low_irq));

// ---- tb/src_core_model.sv ----
// Processor core model: issues sleep instructions and raises wake requests.
`timescale 1ns/1ps
module src_core_model (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Commands from the bench.
	input wire logic sleep_req,
	input wire logic wake_req,
	input wire logic [2:0] wake_delay,
	// Core side signals.
	output logic sleep_instr,
	output logic wake_irq
);
	logic [2:0] wait_cnt;
	// A wake can come promptly or late, so the halt is measured from the request.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_instr <= 1'b0;
			wake_irq <= 1'b0;
			wait_cnt <= 3'h0;
		end else begin
			sleep_instr <= sleep_req;
			wait_cnt <= wake_req ? ((wait_cnt == wake_delay) ? wait_cnt : wait_cnt + 3'h1) : 3'h0;
			wake_irq <= wake_req && wait_cnt == wake_delay;
		end
	end
endmodule : src_core_model

// ---- tb/src_sleep_reset_ctrl_bench.sv ----
// Self-checking bench for the sleep and reset controller.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module src_sleep_reset_ctrl_bench;
	localparam int STARTUP = 4;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
	logic pready, pslverr, rerr, sleep_instr, wake_irq, sleep_req = 1'b0, wake_req = 1'b0;
	logic [2:0] wake_delay = 3'h0;
	logic supply_ok = 1'b1, reset_pin_n = 1'b1, watchdog_timeout = 1'b0, supply_below_level = 1'b0;
	logic watchdog_enable = 1'b1, converter_enable = 1'b0, supply_below_reset = 1'b0;
	logic core_reset_n, port_reset_n, core_halt, clk_cpu_en, clk_io_en, clk_converter_en;
	logic clk_timer_en, oscillator_en, comparator_en, mux_share_en, input_buffer_en;
	logic watchdog_run, extended_conversion, supply_low_irq;
	logic [31:0] g;
	logic [2:0] kinds [5];
	int bad_count = 0, num_checks = 0, cycles = 0, n, t0;
	src_sleep_reset_ctrl #(.STARTUP_CYCLES(STARTUP)) src_sleep_reset_ctrl_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.supply_ok(supply_ok), .reset_pin_n(reset_pin_n), .reset_pin_en(1'b1),
		.watchdog_timeout(watchdog_timeout), .supply_below_level(supply_below_level),
		.supply_below_reset(supply_below_reset), .sleep_instr(sleep_instr), .wake_irq(wake_irq),
		.watchdog_enable(watchdog_enable), .converter_enable(converter_enable),
		.core_reset_n(core_reset_n), .port_reset_n(port_reset_n), .core_halt(core_halt),
		.clk_cpu_en(clk_cpu_en), .clk_io_en(clk_io_en), .clk_converter_en(clk_converter_en),
		.clk_timer_en(clk_timer_en), .oscillator_en(oscillator_en),
		.comparator_en(comparator_en), .mux_share_en(mux_share_en),
		.input_buffer_en(input_buffer_en), .watchdog_run(watchdog_run),
		.extended_conversion(extended_conversion), .supply_low_irq(supply_low_irq));
	src_core_model src_core_model_inst (.pclk(pclk), .presetn(presetn), .sleep_req(sleep_req),
		.wake_req(wake_req), .wake_delay(wake_delay), .sleep_instr(sleep_instr),
		.wake_irq(wake_irq));
	always #2.5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////
	// Expected {io clock, oscillator, input buffers} for a kind; reserved codes act as idle.
	function automatic logic [2:0] exp_clk(input logic [2:0] k);
		logic io;
		io = !(k inside {src_pkg::KIND_NOISE, src_pkg::KIND_POWER_DOWN, src_pkg::KIND_STANDBY});
		return {io, k != src_pkg::KIND_POWER_DOWN, io};
	endfunction : exp_clk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(rdata, e)
	endtask : rd_chk
	task automatic wait_core();
		n = 0;
		while (core_reset_n !== 1'b1) begin
			@(posedge pclk);
			n++;
		end
	endtask : wait_core
	task automatic stop_test();
		$display("bad_count=%0d num_checks=%0d", bad_count, num_checks);
		if (bad_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(92795));
		kinds = '{src_pkg::KIND_IDLE, src_pkg::KIND_NOISE, src_pkg::KIND_POWER_DOWN,
			src_pkg::KIND_STANDBY, 3'h3};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		wait_core();
		rd_chk(src_pkg::SLEEP_CONTROL_ADDR, 32'h0000_0000);
		apb(1'b1, src_pkg::SLEEP_CONTROL_ADDR, 32'hFFFF_FFFE);
		rd_chk(src_pkg::SLEEP_CONTROL_ADDR, 32'h0000_000E);
		apb(1'b0, 8'h14, 32'h0000_0000);
		`CHK({rerr, rdata}, 33'h1_0000_0000)
		repeat (6) begin
			g = $urandom;
			apb(1'b1, src_pkg::CLOCK_GATE_ADDR, g);
			rd_chk(src_pkg::CLOCK_GATE_ADDR, {30'h0, g[1:0]});
			`CHK(clk_timer_en, !g[0])
			`CHK({clk_converter_en, mux_share_en}, {2{!g[1]}})
		end
		apb(1'b1, src_pkg::CLOCK_GATE_ADDR, 32'h0000_0000);
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, src_pkg::SLEEP_CONTROL_ADDR, {28'h0, kinds[i], 1'b1});
			sleep_req <= 1'b1;
			@(posedge pclk);
			sleep_req <= 1'b0;
			repeat (3) @(posedge pclk);
			rd_chk(src_pkg::STATUS_ADDR, {29'h0, src_pkg::SRC_SLEEP});
			`CHK({clk_cpu_en, clk_io_en, oscillator_en, input_buffer_en}, {1'b0, exp_clk(kinds[i])})
			`CHK(comparator_en && kinds[i] == src_pkg::KIND_POWER_DOWN, 1'b0)
			`CHK(watchdog_run, 1'b1)
			wake_delay <= 3'($urandom_range(0, 7));
			wake_req <= 1'b1;
			while (wake_irq !== 1'b1) @(posedge pclk);
			wait_core();
			n = 0;
			while (core_halt !== 1'b0) begin
				@(posedge pclk);
				n++;
			end
			`CHK(n >= 4, 1'b1)
			wake_req <= 1'b0;
			apb(1'b1, src_pkg::SLEEP_CONTROL_ADDR, 32'h0000_0000);
		end
		sleep_req <= 1'b1;
		@(posedge pclk);
		sleep_req <= 1'b0;
		repeat (3) @(posedge pclk);
		rd_chk(src_pkg::STATUS_ADDR, {29'h0, src_pkg::SRC_RUN});
		converter_enable <= 1'b0;
		repeat (3) @(posedge pclk);
		`CHK(extended_conversion, 1'b0)
		converter_enable <= 1'b1;
		repeat (4) @(posedge pclk);
		`CHK(extended_conversion, 1'b1)
		apb(1'b1, src_pkg::SUPPLY_MONITOR_ADDR, 32'h0000_0013);
		supply_below_level <= 1'b1;
		repeat (8) @(posedge pclk);
		`CHK(supply_low_irq, 1'b1)
		apb(1'b0, src_pkg::SUPPLY_MONITOR_ADDR, 32'h0000_0000);
		`CHK(rdata[5], 1'b1)
		supply_below_level <= 1'b0;
		repeat (8) @(posedge pclk);
		`CHK(supply_low_irq, 1'b0)
		apb(1'b1, src_pkg::SUPPLY_MONITOR_ADDR, 32'h0000_0008);
		supply_below_reset <= 1'b1;
		repeat (8) @(posedge pclk);
		`CHK(core_reset_n, 1'b0)
		supply_below_reset <= 1'b0;
		wait_core();
		`CHK(n >= STARTUP, 1'b1)
		// Gating below only happens with the converter switched off.
		converter_enable <= 1'b0;
		for (int s = 0; s < 3; s++) begin
			apb(1'b1, src_pkg::CLOCK_GATE_ADDR, 32'h0000_0003);
			apb(1'b1, src_pkg::RESET_FLAG_ADDR, 32'h0000_0000);
			supply_ok <= (s != 0);
			reset_pin_n <= (s == 2);
			watchdog_timeout <= (s == 2);
			@(posedge pclk);
			t0 = cycles;
			`CHK(port_reset_n, s == 2)
			watchdog_timeout <= 1'b0;
			repeat (5) @(posedge pclk);
			`CHK({port_reset_n, core_reset_n}, 2'b00)
			supply_ok <= 1'b1;
			if (s != 2) begin
				repeat (20) @(posedge pclk);
				`CHK(core_reset_n, 1'b0)
				reset_pin_n <= 1'b1;
			end
			wait_core();
			`CHK((((s == 2) ? cycles - t0 : n) >= STARTUP), 1'b1)
			rd_chk(src_pkg::CLOCK_GATE_ADDR, 32'h0000_0000);
			apb(1'b0, src_pkg::RESET_FLAG_ADDR, 32'h0000_0000);
			`CHK(rdata[s], 1'b1)
		end
		stop_test();
	end
endmodule : src_sleep_reset_ctrl_bench
